//--- rtl/fcb_sci.v
// serial port of the boot link: 8 data bits, 1 stop bit, no parity
`timescale 1ns/1ps
`default_nettype none
module fcb_sci #(
	parameter DW = 16
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          rxd_s,
	input  wire          rx_en,
	input  wire          tx_en,
	input  wire [DW-1:0] bit_cycles,
	input  wire          tx_start,
	input  wire [7:0]    tx_data,
	output reg           rx_valid,
	output reg  [7:0]    rx_data,
	output wire          tx_busy,
	output reg           txd
);
	reg [DW-1:0] rx_cnt;
	reg [3:0]    rx_bit;
	reg          rx_act;
	reg [7:0]    rx_sh;
	reg [DW-1:0] tx_cnt;
	reg [3:0]    tx_bit;
	reg [8:0]    tx_sh;
	reg          tx_act;
	assign tx_busy = tx_act | tx_start;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_cnt   <= {DW{1'b0}};
			rx_bit   <= 4'h0;
			rx_act   <= 1'b0;
			rx_sh    <= 8'h00;
			rx_valid <= 1'b0;
			rx_data  <= 8'h00;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_en) begin
				rx_act <= 1'b0;
			end else if (!rx_act) begin
				if (!rxd_s) begin
					rx_act <= 1'b1;
					rx_bit <= 4'h0;
					// first sample lands mid start bit
					rx_cnt <= bit_cycles >> 1;
				end
			end else if (rx_cnt != {DW{1'b0}}) begin
				rx_cnt <= rx_cnt - {{(DW-1){1'b0}}, 1'b1};
			end else begin
				rx_cnt <= bit_cycles;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0 && rxd_s)
					rx_act <= 1'b0;
				else if (rx_bit >= 4'h1 && rx_bit <= 4'h8)
					rx_sh <= {rxd_s, rx_sh[7:1]};
				else if (rx_bit == 4'h9) begin
					rx_act <= 1'b0;
					// a broken stop bit drops the byte
					rx_valid <= rxd_s;
					rx_data  <= rx_sh;
				end
			end
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_cnt <= {DW{1'b0}};
			tx_bit <= 4'h0;
			tx_sh  <= 9'h1ff;
			tx_act <= 1'b0;
			txd    <= 1'b1;
		end else if (!tx_en) begin
			tx_act <= 1'b0;
			txd    <= 1'b1;
		end else if (!tx_act) begin
			if (tx_start) begin
				tx_act <= 1'b1;
				tx_sh  <= {1'b1, tx_data};
				tx_bit <= 4'h0;
				tx_cnt <= bit_cycles;
				txd    <= 1'b0;
			end
		end else if (tx_cnt != {DW{1'b0}}) begin
			tx_cnt <= tx_cnt - {{(DW-1){1'b0}}, 1'b1};
		end else begin
			tx_cnt <= bit_cycles;
			tx_bit <= tx_bit + 4'h1;
			if (tx_bit == 4'h9) begin
				tx_act <= 1'b0;
				txd    <= 1'b1;
			end else begin
				txd   <= tx_sh[0];
				tx_sh <= {1'b1, tx_sh[8:1]};
			end
		end
	end
endmodule
`default_nettype wire

//--- rtl/fcb_top.v
// flash control registers, strap mode select and serial boot loader
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fcb_defs.vh"
module fcb_top #(
	parameter LARGE_ARRAY = 1,
	parameter BW          = 16
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [11:0]   paddr,
	input  wire [31:0]   pwdata,
	output wire          pready,
	output reg  [31:0]   prdata,
	output reg           pslverr,
	input  wire          test_strap,
	input  wire          strap_a,
	input  wire          strap_b,
	input  wire          port_b_strap_0,
	input  wire          port_b_strap_1,
	input  wire          port_b_strap_2,
	input  wire          rxd,
	output wire          txd,
	input  wire          flash_fault,
	input  wire          subactive,
	input  wire          watchdog_overflow,
	input  wire [15:0]   flash_addr,
	output wire          erase_addr_ok,
	output wire [4:0]    erase_allow,
	output wire [5:0]    flash_op,
	output wire          flash_power_down,
	output wire [1:0]    mode,
	output reg           erase_all_req,
	input  wire          erase_all_done,
	output reg           ram_we,
	output reg  [15:0]   ram_addr,
	output reg  [7:0]    ram_wdata,
	output reg           boot_branch,
	output reg           boot_fail
);
	localparam S_IDLE  = 4'h0;
	localparam S_WAIT  = 4'h1;
	localparam S_HIGH  = 4'h2;
	localparam S_LOW   = 4'h3;
	localparam S_SEND  = 4'h4;
	localparam S_ACK   = 4'h5;
	localparam S_LENH  = 4'h6;
	localparam S_LENL  = 4'h7;
	localparam S_LOAD  = 4'h8;
	localparam S_ERASE = 4'h9;
	localparam S_RUN   = 4'ha;
	localparam S_FAIL  = 4'hb;
	localparam [15:0] RAM_SPAN = `FCB_RAM_END - `FCB_RAM_BASE + 16'h0001;
	localparam [15:0] BLK4_END = LARGE_ARRAY ? `FCB_BLK4_END_L : `FCB_BLK4_END_S;
	localparam [7:0]  READY_CNT = `FCB_READY_STATES;

	// pin synchronisers: test, a, b, pb0, pb1, pb2, rxd
	wire [6:0] pin_raw = {rxd, port_b_strap_2, port_b_strap_1, port_b_strap_0,
		strap_b, strap_a, test_strap};
	wire [6:0] pin_s;
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1) begin : g_sync
			reg s1;
			reg s2;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1 <= 1'b1;
					s2 <= 1'b1;
				end else begin
					s1 <= pin_raw[g];
					s2 <= s1;
				end
			end
			assign pin_s[g] = s2;
		end
	endgenerate
	wire rxd_s = pin_s[6];

	reg [6:0] ctrl;
	reg       fault;
	reg       pdd;
	reg [4:0] eblk;
	reg       acc_en;
	reg [1:0] mode_q;
	reg [1:0] lat_cnt;
	reg       mode_done;

	// strap capture a few edges after release, past the synchroniser
	// strap mode decode
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q    <= `FCB_MODE_NONE;
			lat_cnt   <= 2'h0;
			mode_done <= 1'b0;
		end else if (!mode_done) begin
			lat_cnt <= lat_cnt + 2'h1;
			if (lat_cnt == `FCB_STRAP_LAT) begin
				mode_done <= 1'b1;
				if (!pin_s[0] && pin_s[1])
					mode_q <= `FCB_MODE_USER;
				else if (!pin_s[0] && !pin_s[1] && pin_s[2])
					mode_q <= `FCB_MODE_BOOT;
				else if (pin_s[0] && pin_s[5:3] == 3'h0)
					mode_q <= `FCB_MODE_PROG;
			end
		end else if (watchdog_overflow && mode_q == `FCB_MODE_BOOT) begin
			mode_q <= `FCB_MODE_USER;
		end
	end
	assign mode = mode_q;

	// apb: zero wait, read data captured in setup phase
	assign pready = 1'b1;
	wire wr_acc = psel & penable & pwrite;
	wire rd_set = psel & ~penable & ~pwrite;
	wire prot_hit = (paddr == `FCB_OFF_CTRL) | (paddr == `FCB_OFF_STAT) |
		(paddr == `FCB_OFF_PWR) | (paddr == `FCB_OFF_EBLK);
	wire mapped = prot_hit | (paddr == `FCB_OFF_EN) | (paddr == `FCB_OFF_BOOT);
	wire prot_ok = ~prot_hit | acc_en;
	wire [4:0] wb = pwdata[4:0];
	wire multi = (wb & (wb - 5'h01)) != 5'h00;
	reg  [BW-1:0] bit_cycles;
	reg  [3:0]    state;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl   <= 7'h00;
			fault  <= 1'b0;
			pdd    <= 1'b0;
			eblk   <= 5'h00;
			acc_en <= 1'b0;
		end else begin
			if (flash_fault && ctrl[5:0] != 6'h00)
				fault <= 1'b1;
			if (wr_acc && paddr == `FCB_OFF_EN)
				acc_en <= pwdata[`FCB_ENA_BIT];
			if (wr_acc && acc_en && paddr == `FCB_OFF_PWR)
				pdd <= pwdata[`FCB_PDD_BIT];
			if (wr_acc && acc_en && paddr == `FCB_OFF_CTRL) begin
				ctrl[`FCB_SWE_BIT] <= pwdata[`FCB_SWE_BIT];
				// low bits need write enable
				// error protection refuses new op bits until reset
				ctrl[5:0] <= (ctrl[`FCB_SWE_BIT] & pwdata[`FCB_SWE_BIT] & ~fault) ?
					pwdata[5:0] : 6'h00;
			end else if (!ctrl[`FCB_SWE_BIT] || fault) begin
				// error protection also drops program and erase
				ctrl[5:0] <= 6'h00;
			end
			if (!ctrl[`FCB_SWE_BIT])
				eblk <= 5'h00;
			else if (wr_acc && acc_en && paddr == `FCB_OFF_EBLK)
				eblk <= multi ? 5'h00 : wb;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= ~mapped;
			prdata  <= 32'h00000000;
			if (rd_set && prot_ok) begin
				case (paddr)
				`FCB_OFF_CTRL: prdata[6:0] <= ctrl;
				`FCB_OFF_STAT: prdata[`FCB_FAULT_BIT] <= fault;
				`FCB_OFF_PWR:  prdata[`FCB_PDD_BIT] <= pdd;
				`FCB_OFF_EBLK: prdata[4:0] <= eblk;
				`FCB_OFF_EN:   prdata[`FCB_ENA_BIT] <= acc_en;
				`FCB_OFF_BOOT: prdata <= {{(16-BW){1'b0}}, bit_cycles,
					4'h0, state, 6'h00, mode_q};
				default:       prdata <= 32'h00000000;
				endcase
			end
		end
	end

	assign erase_allow = eblk;
	assign flash_op    = ctrl[5:0];
	wire [4:0] in_blk;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_blk
			assign in_blk[g] = flash_addr[15:`FCB_BLK_SIZE_LOG] == g;
		end
	endgenerate
	assign in_blk[4] = flash_addr >= `FCB_BLK4_BASE && flash_addr <= BLK4_END;
	assign erase_addr_ok = (in_blk & eblk) != 5'h00;
	assign flash_power_down = subactive & ~pdd;

	// boot loader
	reg  [7:0]    wait_cnt;
	reg  [3:0]    div9;
	reg  [BW-1:0] low_cnt;
	reg  [15:0]   len;
	reg           rx_en;
	reg           tx_en;
	reg           tx_start;
	wire          rx_valid;
	wire [7:0]    rx_data;
	wire          tx_busy;
	wire          in_boot = mode_q == `FCB_MODE_BOOT;

	fcb_sci #(
		.DW(BW)
	) u_sci (
		.pclk       (pclk),
		.presetn    (presetn),
		.rxd_s      (rxd_s),
		.rx_en      (rx_en),
		.tx_en      (tx_en),
		.bit_cycles (bit_cycles),
		.tx_start   (tx_start),
		.tx_data    (`FCB_SYNC_BYTE),
		.rx_valid   (rx_valid),
		.rx_data    (rx_data),
		.tx_busy    (tx_busy),
		.txd        (txd)
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state         <= S_IDLE;
			wait_cnt      <= 8'h00;
			div9          <= 4'h0;
			low_cnt       <= {BW{1'b0}};
			bit_cycles    <= {BW{1'b1}};
			len           <= 16'h0000;
			rx_en         <= 1'b0;
			tx_en         <= 1'b0;
			tx_start      <= 1'b0;
			erase_all_req <= 1'b0;
			ram_we        <= 1'b0;
			ram_addr      <= `FCB_RAM_BASE;
			ram_wdata     <= 8'h00;
			boot_branch   <= 1'b0;
			boot_fail     <= 1'b0;
		end else begin
			tx_start <= 1'b0;
			ram_we   <= 1'b0;
			if (!in_boot && state != S_IDLE) begin
				state         <= S_IDLE;
				rx_en         <= 1'b0;
				tx_en         <= 1'b0;
				erase_all_req <= 1'b0;
			end else begin
				case (state)
				S_IDLE: if (in_boot) begin
					state    <= S_WAIT;
					wait_cnt <= 8'h00;
				end
				// settle before measuring
				// host may already be mid-byte: wait for a high line first
				S_WAIT: if (wait_cnt != READY_CNT - 8'h01)
					wait_cnt <= wait_cnt + 8'h01;
				else if (rxd_s)
					state <= S_HIGH;
				S_HIGH: if (!rxd_s) begin
					state   <= S_LOW;
					div9    <= 4'h1;
					low_cnt <= {BW{1'b0}};
				end
				// start bit plus eight zero bits span nine bit times
				S_LOW: if (rxd_s) begin
					bit_cycles <= low_cnt;
					tx_en      <= 1'b1;
					tx_start   <= 1'b1;
					state      <= S_SEND;
				end else if (div9 == `FCB_BITS_PER_LOW) begin
					div9    <= 4'h1;
					low_cnt <= low_cnt + {{(BW-1){1'b0}}, 1'b1};
				end else begin
					div9 <= div9 + 4'h1;
				end
				S_SEND: if (!tx_busy) begin
					rx_en <= 1'b1;
					state <= S_ACK;
				end
				S_ACK: if (rx_valid) begin
					if (rx_data == `FCB_ACK_BYTE)
						state <= S_LENH;
					else if (rx_data != `FCB_SYNC_BYTE)
						state <= S_FAIL;
				end
				S_LENH: if (rx_valid) begin
					len[15:8] <= rx_data;
					state     <= S_LENL;
				end
				S_LENL: if (rx_valid) begin
					len      <= {len[15:8], rx_data} > RAM_SPAN ?
						RAM_SPAN : {len[15:8], rx_data};
					ram_addr <= `FCB_RAM_BASE;
					state    <= S_LOAD;
				end
				S_LOAD: if (len == 16'h0000) begin
					erase_all_req <= 1'b1;
					state         <= S_ERASE;
				end else if (rx_valid) begin
					ram_we    <= 1'b1;
					ram_wdata <= rx_data;
					len       <= len - 16'h0001;
					if (ram_we)
						ram_addr <= ram_addr + 16'h0001;
				end else if (ram_we) begin
					ram_addr <= ram_addr + 16'h0001;
				end
				// stop link, keep rate, line idles high
				S_ERASE: if (erase_all_done) begin
					erase_all_req <= 1'b0;
					rx_en         <= 1'b0;
					tx_en         <= 1'b0;
					boot_branch   <= 1'b1;
					state         <= S_RUN;
				end
				S_RUN: boot_branch <= 1'b1;
				S_FAIL: begin
					boot_fail <= 1'b1;
					rx_en     <= 1'b0;
				end
				default: state <= S_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- shared/fcb_defs.vh
// register map, field positions and timing counts of the flash/boot block
`ifndef FCB_DEFS_VH
`define FCB_DEFS_VH
`define FCB_OFF_CTRL      12'h000
`define FCB_OFF_STAT      12'h004
`define FCB_OFF_PWR       12'h008
`define FCB_OFF_EBLK      12'h00c
`define FCB_OFF_EN        12'h010
`define FCB_OFF_BOOT      12'h014
`define FCB_RST_BYTE      8'h00
`define FCB_SWE_BIT       6
`define FCB_FAULT_BIT     7
`define FCB_PDD_BIT       7
`define FCB_ENA_BIT       7
`define FCB_NBLK          5
`define FCB_BLK_SIZE_LOG  10
`define FCB_BLK4_BASE     16'h1000
`define FCB_BLK4_END_L    16'h7fff
`define FCB_BLK4_END_S    16'h3fff
`define FCB_RAM_BASE      16'hf780
`define FCB_RAM_END       16'hfeef
`define FCB_READY_STATES  8'h64
`define FCB_STRAP_LAT     2'h3
`define FCB_SYNC_BYTE     8'h00
`define FCB_ACK_BYTE      8'h55
`define FCB_BITS_PER_LOW  4'h9
`define FCB_MODE_NONE     2'h0
`define FCB_MODE_USER     2'h1
`define FCB_MODE_BOOT     2'h2
`define FCB_MODE_PROG     2'h3
`endif

//--- verif/fcb_host_model.sv
// serial host that runs the boot handshake and sends a two byte program
`timescale 1ns/1ps
`default_nettype none
module fcb_host_model #(
	parameter int BIT = 40
) (
	input  wire logic       pclk,
	input  wire logic       go,
	input  wire logic [7:0] ack,
	input  wire logic       txd,
	output var  logic       rxd,
	output var  logic [7:0] sync_byte
);
	logic got = 1'b0;
	// start, 8 data lsb first, stop
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge pclk);
		end
	endtask
	initial begin
		rxd = 1'b1;
		forever begin
			wait (go === 1'b1);
			@(posedge pclk);
			while (!got) send(8'h00);
			repeat (2 * BIT) @(posedge pclk);
			// answer only a clean zero byte
			if (sync_byte === 8'h00) begin
				send(ack);
				send(8'h00);
				send(8'h02);
				send(8'ha5);
				send(8'h3c);
			end
			// one session per raise of go
			wait (go === 1'b0);
		end
	end
	initial begin
		forever begin
			wait (go === 1'b1);
			got = 1'b0;
			sync_byte = 8'hff;
			@(negedge txd);
			repeat (BIT + BIT / 2) @(posedge pclk);
			for (int i = 0; i < 8; i++) begin
				sync_byte[i] = txd;
				repeat (BIT) @(posedge pclk);
			end
			got = 1'b1;
			wait (go === 1'b0);
		end
	end
endmodule
`default_nettype wire

//--- verif/fcb_top_sva.sv
// assertion checker bound to the flash register and boot loader block
`timescale 1ns/1ps
`default_nettype none
module fcb_top_sva #(
	parameter LARGE_ARRAY = 1
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        txd,
	input wire logic        flash_fault,
	input wire logic        subactive,
	input wire logic        watchdog_overflow,
	input wire logic [15:0] flash_addr,
	input wire logic        erase_addr_ok,
	input wire logic [4:0]  erase_allow,
	input wire logic [5:0]  flash_op,
	input wire logic        flash_power_down,
	input wire logic [1:0]  mode,
	input wire logic        erase_all_req,
	input wire logic        ram_we,
	input wire logic [15:0] ram_addr,
	input wire logic        boot_branch
);
	localparam logic [15:0] blk4_end = LARGE_ARRAY ? 16'h7fff : 16'h3fff;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_fault_stops_ops: assert property (flash_fault && flash_op != 6'h00 |-> ##[1:2] flash_op == 6'h00)
		else $error("op bits survive a flash fault");
	a_single_block: assert property ($onehot0(erase_allow))
		else $error("more than one erase block selected");
	a_sel_allows: assert property ((flash_addr < 16'h1000 && erase_allow[flash_addr[11:10]])
		|| (erase_allow[4] && flash_addr >= 16'h1000 && flash_addr <= blk4_end) |-> erase_addr_ok)
		else $error("selected block refused for erase");
	a_block_map: assert property (erase_addr_ok |-> (flash_addr < 16'h1000 ? erase_allow[flash_addr[11:10]]
		: (erase_allow[4] && flash_addr <= blk4_end)))
		else $error("erase allowed outside the selected block");
	a_power_down: assert property (flash_power_down |-> subactive)
		else $error("flash powered down outside subactive mode");
	a_mode_hold: assert property (mode != 2'h0 && !watchdog_overflow |=> $stable(mode))
		else $error("mode changed without reset or watchdog");
	a_ram_window: assert property (ram_we |-> mode == 2'h2 && ram_addr >= 16'hf780 && ram_addr <= 16'hfeef)
		else $error("program byte stored outside the loader window");
	a_branch_quiet: assert property (boot_branch |-> txd && !ram_we && !erase_all_req)
		else $error("serial or loader activity after branch");
	a_wdog_exit: assert property (mode == 2'h2 && watchdog_overflow |=> mode == 2'h1)
		else $error("watchdog overflow did not leave boot mode");
endmodule
bind fcb_top fcb_top_sva #(.LARGE_ARRAY(LARGE_ARRAY)) i_sva (
	.pclk(pclk), .presetn(presetn), .txd(txd), .flash_fault(flash_fault), .subactive(subactive),
	.watchdog_overflow(watchdog_overflow), .flash_addr(flash_addr), .erase_addr_ok(erase_addr_ok),
	.erase_allow(erase_allow), .flash_op(flash_op), .flash_power_down(flash_power_down), .mode(mode),
	.erase_all_req(erase_all_req), .ram_we(ram_we), .ram_addr(ram_addr), .boot_branch(boot_branch)
);
`default_nettype wire

//--- verif/fcb_top_test.sv
// self-checking bench for the flash register and boot loader block
`timescale 1ns/1ps
`default_nettype none
module fcb_top_test;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, perr;
	logic        test_strap = 1'b0, strap_a = 1'b1, strap_b = 1'b0, host_go = 1'b0;
	logic        port_b_strap_0 = 1'b1, port_b_strap_1 = 1'b1, port_b_strap_2 = 1'b1;
	logic        flash_fault = 1'b0, subactive = 1'b0, wdog = 1'b0, erase_done = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [7:0]  host_ack = 8'h55;
	logic [31:0] pwdata = 32'h0, rdat;
	logic [15:0] flash_addr = 16'h0, lo, hi;
	logic [23:0] ram_q[$];
	wire         pready, pslverr, rxd, txd, addr_ok, pdown, erase_req, ram_we, branch, fail;
	wire  [31:0] prdata;
	wire  [15:0] ram_addr;
	wire  [7:0]  ram_wdata, host_byte;
	wire  [5:0]  flash_op;
	wire  [4:0]  erase_allow;
	wire  [1:0]  mode;
	int          err_total = 0, compares = 0;
	fcb_top #(.LARGE_ARRAY(1), .BW(16)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .test_strap(test_strap),
		.strap_a(strap_a), .strap_b(strap_b), .port_b_strap_0(port_b_strap_0), .port_b_strap_1(port_b_strap_1),
		.port_b_strap_2(port_b_strap_2), .rxd(rxd), .txd(txd), .flash_fault(flash_fault), .subactive(subactive),
		.watchdog_overflow(wdog), .flash_addr(flash_addr), .erase_addr_ok(addr_ok), .erase_allow(erase_allow),
		.flash_op(flash_op), .flash_power_down(pdown), .mode(mode), .erase_all_req(erase_req),
		.erase_all_done(erase_done), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.boot_branch(branch), .boot_fail(fail)
	);
	fcb_host_model #(.BIT(40)) i_host (.pclk(pclk), .go(host_go), .ack(host_ack), .txd(txd), .rxd(rxd),
		.sync_byte(host_byte));
	always #2 pclk = ~pclk;
	always @(posedge pclk) if (ram_we === 1'b1) ram_q.push_back({ram_addr, ram_wdata});
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rdat, e);
	endtask
	task automatic probe(input logic [15:0] a, input logic e);
		flash_addr <= a;
		@(posedge pclk);
		check(addr_ok, e);
	endtask
	// straps set inside reset, held after it
	task automatic restart(input logic [5:0] s);
		presetn <= 1'b0;
		{test_strap, strap_a, strap_b, port_b_strap_0, port_b_strap_1, port_b_strap_2} <= s;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask
	task automatic t_modes;
		logic [5:0] st[5];
		logic [1:0] me[5];
		st = '{6'b010000, 6'b001111, 6'b100000, 6'b110001, 6'b000111};
		me = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
		for (int i = 0; i < 5; i++) begin
			restart(st[i]);
			check(mode, me[i]);
		end
	endtask
	task automatic t_regs;
		restart(6'b010000);
		rd(12'h010, 32'h0);
		wr(12'h000, 32'h40);
		wr(12'h010, 32'hffffffff);
		rd(12'h000, 32'h0);
		rd(12'h010, 32'h80);
		wr(12'h000, 32'h3f);
		rd(12'h000, 32'h0);
		wr(12'h00c, 32'h4);
		rd(12'h00c, 32'h0);
		wr(12'h000, 32'h40);
		wr(12'h00c, 32'h3);
		rd(12'h00c, 32'h0);
		for (int b = 0; b < 5; b++) begin
			wr(12'h00c, 32'h1 << b);
			check(erase_allow, 5'h1 << b);
			lo = (b < 4) ? 16'(b * 1024) : 16'h1000;
			hi = (b < 4) ? lo + 16'h3ff : 16'h7fff;
			probe(lo, 1'b1);
			probe(hi, 1'b1);
			probe(lo - 16'h1, 1'b0);
			probe(hi + 16'h1, 1'b0);
		end
		wr(12'h000, 32'h0);
		rd(12'h00c, 32'h0);
		subactive <= 1'b1;
		wr(12'h008, 32'hff);
		rd(12'h008, 32'h80);
		check(pdown, 1'b0);
		wr(12'h008, 32'h0);
		check(pdown, 1'b1);
		rd(12'h004, 32'h0);
		wr(12'h000, 32'h40);
		wr(12'h000, 32'h41);
		check(flash_op, 6'h01);
		flash_fault <= 1'b1;
		@(posedge pclk);
		flash_fault <= 1'b0;
		rd(12'h004, 32'h80);
		wr(12'h004, 32'h0);
		rd(12'h004, 32'h80);
		check(flash_op, 6'h00);
		wr(12'h000, 32'h41);
		check(flash_op, 6'h00);
		rd(12'h020, 32'h0);
		check(perr, 1'b1);
		wr(12'h010, 32'h0);
		rd(12'h004, 32'h0);
	endtask
	task automatic t_boot;
		restart(6'b001000);
		check(mode, 2'h2);
		host_go <= 1'b1;
		while (erase_req !== 1'b1) @(posedge pclk);
		repeat (2) @(posedge pclk);
		check(host_byte, 8'h00);
		check(ram_q.size(), 2);
		check(ram_q[0], 24'hf780a5);
		check(ram_q[1], 24'hf7813c);
		erase_done <= 1'b1;
		@(posedge pclk);
		erase_done <= 1'b0;
		repeat (4) @(posedge pclk);
		check({branch, txd, fail}, 3'b110);
		apb(1'b0, 12'h014, 32'h0);
		check(rdat[31:16] >= 16'h0027 && rdat[31:16] <= 16'h0029, 1'b1);
		wdog <= 1'b1;
		@(posedge pclk);
		wdog <= 1'b0;
		repeat (2) @(posedge pclk);
		check(mode, 2'h1);
	endtask
	// bad answer to the sync byte: loader must give up, store nothing
	task automatic t_boot_fail;
		host_go <= 1'b0;
		restart(6'b001000);
		host_ack <= 8'h33;
		host_go <= 1'b1;
		while (fail !== 1'b1) @(posedge pclk);
		repeat (1700) @(posedge pclk);
		check({branch, erase_req, fail}, 3'b001);
		check(ram_q.size(), 2);
		check(host_byte, 8'h00);
	endtask
	task automatic wrap_up;
		if (err_total == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// boot run is a few thousand cycles, registers far less
	initial begin
		repeat (60000) @(posedge pclk);
		err_total++;
		wrap_up();
	end
	initial begin
		@(posedge pclk);
		t_modes();
		t_regs();
		t_boot();
		t_boot_fail();
		wrap_up();
	end
endmodule
`default_nettype wire
